// ===== src/sdm_data_mem.sv
`default_nettype none
module sdm_data_mem
  import sdm_pkg::*;
#(
  parameter int SECTORS = SDM_SECTORS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire sdm_req_s REQ,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic [7:0] SFR_ADDR,
  output logic SFR_RD,
  output logic SFR_WR,
  output logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_HIT,
  input wire logic SFR_RO,
  output logic [7:0] PTR0,
  output logic [7:0] PTR1_LOW,
  output logic [7:0] PTR1_SECTOR,
  output logic [7:0] PTR2_LOW,
  output logic [7:0] PTR2_SECTOR
);
  localparam int RAW = $clog2(SECTORS) + 7;

  if (SECTORS != SDM_SECTORS) begin : g_bad_sectors
    $error("sdm_data_mem: only four sectors are served");
  end

  logic [7:0] ptr0_reg;
  logic [7:0] ptr1l_reg;
  logic [7:0] ptr1s_reg;
  logic [7:0] ptr2l_reg;
  logic [7:0] ptr2s_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [7:0] sfr_addr_reg;
  logic sfr_rd_reg;
  logic sfr_wr_reg;
  logic [7:0] sfr_wdata_reg;

  // first step: what location does the instruction name
  function automatic sdm_loc_s name_loc(input sdm_req_s r);
    sdm_loc_s l;
    l.offset = r.addr[7:0];
    if (r.mode == SDM_MODE_EXT) begin
      l.sector = r.addr[SDM_SEC_W+7:8];
      l.sector_ok = 1'b1; // ten bits leave no spare sector bits
    end else begin
      l.sector = '0;
      l.sector_ok = 1'b1;
    end
    return l;
  endfunction

  function automatic logic is_port(input sdm_loc_s l);
    return (l.sector == '0) && ((l.offset == SDM_OFF_PORT0) || (l.offset == SDM_OFF_PORT1) ||
           (l.offset == SDM_OFF_PORT2));
  endfunction

  function automatic logic is_gp(input logic [7:0] off);
    return off >= SDM_GP_BASE;
  endfunction

  // pointer high bytes are 8 bits; sectors beyond the last do not exist
  function automatic sdm_loc_s ptr_loc(input logic [7:0] hi, input logic [7:0] lo);
    sdm_loc_s l;
    l.sector = hi[SDM_SEC_W-1:0];
    l.sector_ok = (hi[7:SDM_SEC_W] == '0);
    l.offset = lo;
    return l;
  endfunction

  sdm_loc_s named;
  sdm_loc_s tgt;
  logic via_port;

  // second step: an indirect port redirects through its pointer
  always_comb begin
    named = name_loc(REQ);
    via_port = named.sector_ok && is_port(named);
    tgt = named;
    if (via_port) begin
      case (named.offset)
        SDM_OFF_PORT0: begin
          tgt.sector = '0;
          tgt.sector_ok = 1'b1;
          tgt.offset = ptr0_reg;
        end
        SDM_OFF_PORT1: tgt = ptr_loc(ptr1s_reg, ptr1l_reg);
        default: tgt = ptr_loc(ptr2s_reg, ptr2l_reg);
      endcase
    end
  end

  logic tgt_port;
  logic tgt_gp;
  logic tgt_local;
  logic tgt_sfr;
  logic is_wr;
  logic [7:0] local_val;

  always_comb begin
    tgt_port = tgt.sector_ok && is_port(tgt);
    tgt_gp = tgt.sector_ok && is_gp(tgt.offset) && (int'(tgt.sector) < SECTORS);
    tgt_local = 1'b0;
    local_val = SDM_ZERO;
    if (tgt.sector_ok && tgt.sector == '0) begin
      tgt_local = 1'b1;
      case (tgt.offset)
        SDM_OFF_PTR0: local_val = ptr0_reg;
        SDM_OFF_PTR1L: local_val = ptr1l_reg;
        SDM_OFF_PTR1S: local_val = ptr1s_reg;
        SDM_OFF_PTR2L: local_val = ptr2l_reg;
        SDM_OFF_PTR2S: local_val = ptr2s_reg;
        default: tgt_local = 1'b0;
      endcase
    end
    tgt_sfr = tgt.sector_ok && !tgt_gp && !tgt_port && !tgt_local && !is_gp(tgt.offset);
    is_wr = REQ.valid && (REQ.op != SDM_OP_READ);
  end

  // bit ops are read-modify-write in one cycle
  function automatic logic [7:0] modify(input sdm_req_s r, input logic [7:0] old);
    logic [7:0] m;
    m = 8'h01 << r.bitsel;
    case (r.op)
      SDM_OP_BSET: return old | m;
      SDM_OP_BCLR: return old & ~m;
      default: return r.wdata;
    endcase
  endfunction

  logic [RAW-1:0] ram_addr;
  logic [7:0] ram_rdata;
  logic [7:0] cur_val;
  logic [7:0] new_val;

  assign ram_addr = {tgt.sector[$clog2(SECTORS)-1:0], tgt.offset[6:0]};

  sdm_gp_ram #(.SECTORS(SECTORS)) u_ram (
    .clk(CLK),
    .we(is_wr && tgt_gp),
    .waddr(ram_addr),
    .wdata(new_val),
    .raddr(ram_addr),
    .rdata(ram_rdata)
  );

  // sfr bit ops work on the value the sfr side returns combinationally
  always_comb begin
    if (tgt_gp) cur_val = ram_rdata;
    else if (tgt_local) cur_val = local_val;
    else if (tgt_sfr && SFR_HIT) cur_val = SFR_RDATA;
    else cur_val = SDM_ZERO;
    new_val = modify(REQ, cur_val);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ptr0_reg <= SDM_PTR_RESET;
      ptr1l_reg <= SDM_PTR_RESET;
      ptr1s_reg <= SDM_PTR_RESET;
      ptr2l_reg <= SDM_PTR_RESET;
      ptr2s_reg <= SDM_PTR_RESET;
    end else if (is_wr && tgt_local) begin
      case (tgt.offset)
        SDM_OFF_PTR0: ptr0_reg <= new_val;
        SDM_OFF_PTR1L: ptr1l_reg <= new_val;
        SDM_OFF_PTR1S: ptr1s_reg <= new_val;
        SDM_OFF_PTR2L: ptr2l_reg <= new_val;
        SDM_OFF_PTR2S: ptr2s_reg <= new_val;
        default: ptr0_reg <= ptr0_reg;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= SDM_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= REQ.valid && (REQ.op == SDM_OP_READ);
      if (REQ.valid && REQ.op == SDM_OP_READ) begin
        rdata_reg <= cur_val;
      end
    end
  end

  // sfr strobes registered; read-only targets get no write strobe
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sfr_addr_reg <= SDM_ZERO;
      sfr_rd_reg <= 1'b0;
      sfr_wr_reg <= 1'b0;
      sfr_wdata_reg <= SDM_ZERO;
    end else begin
      sfr_addr_reg <= tgt.offset;
      sfr_rd_reg <= REQ.valid && (REQ.op == SDM_OP_READ) && tgt_sfr && SFR_HIT;
      sfr_wr_reg <= is_wr && tgt_sfr && SFR_HIT && !SFR_RO;
      sfr_wdata_reg <= new_val;
    end
  end

  assign RDATA = rdata_reg;
  assign RVALID = rvalid_reg;
  assign SFR_ADDR = sfr_addr_reg;
  assign SFR_RD = sfr_rd_reg;
  assign SFR_WR = sfr_wr_reg;
  assign SFR_WDATA = sfr_wdata_reg;
  assign PTR0 = ptr0_reg;
  assign PTR1_LOW = ptr1l_reg;
  assign PTR1_SECTOR = ptr1s_reg;
  assign PTR2_LOW = ptr2l_reg;
  assign PTR2_SECTOR = ptr2s_reg;

  // last ram write, so a read of the same byte just after it can be checked
  logic last_wr_reg;
  logic [RAW-1:0] last_addr_reg;
  logic [7:0] last_val_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      last_wr_reg <= 1'b0;
      last_addr_reg <= '0;
      last_val_reg <= SDM_ZERO;
    end else begin
      last_wr_reg <= is_wr && tgt_gp;
      last_addr_reg <= ram_addr;
      last_val_reg <= new_val;
    end
  end

  // decode and redirection
  a_port_read_zero: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_READ && tgt_port) |=> (RDATA == SDM_ZERO && RVALID))
    else $error("port as target did not read zero");
  a_port_write_none: assert property (@(posedge CLK) disable iff (RST)
    (is_wr && tgt_port) |=> (!SFR_WR && $stable(PTR0) && $stable(PTR1_LOW)))
    else $error("port as target changed state");
  a_ptr_write_back: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_WRITE && tgt_local && tgt.offset == SDM_OFF_PTR0)
      |=> (PTR0 == $past(REQ.wdata)))
    else $error("pointer zero not written");
  a_port0_sector0: assert property (@(posedge CLK) disable iff (RST)
    (via_port && named.offset == SDM_OFF_PORT0) |-> (tgt.sector == '0 && tgt.offset == PTR0))
    else $error("first port left sector zero");
  a_port1_follow: assert property (@(posedge CLK) disable iff (RST)
    (via_port && named.offset == SDM_OFF_PORT1 && PTR1_SECTOR < 8'h04)
      |-> (tgt.sector == PTR1_SECTOR[1:0] && tgt.offset == PTR1_LOW))
    else $error("second port not following its pointer");
  a_direct_sector0: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.mode == SDM_MODE_DIRECT && !via_port) |-> (tgt.sector == '0))
    else $error("direct access left sector zero");
  a_ro_no_write: assert property (@(posedge CLK) disable iff (RST)
    (is_wr && SFR_RO) |=> !SFR_WR)
    else $error("write strobe to read-only register");
  a_unused_zero: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_READ && tgt_sfr && !SFR_HIT) |=> (RDATA == SDM_ZERO))
    else $error("unused address not zero");
  a_sfr_no_ram: assert property (@(posedge CLK) disable iff (RST)
    (tgt.sector_ok && tgt.offset <= SDM_SFR_LAST) |-> !tgt_gp)
    else $error("low half decoded to ram");
  a_ext_sector_pick: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.mode == SDM_MODE_EXT && !via_port)
      |-> (tgt.sector == REQ.addr[SDM_SEC_W+7:8] && tgt.offset == REQ.addr[7:0]))
    else $error("extended address split wrongly");
  a_ext_reach_all: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.mode == SDM_MODE_EXT && !via_port && REQ.addr[7:0] >= SDM_GP_BASE)
      |-> tgt_gp)
    else $error("extended access missed general ram");
  a_port2_follow: assert property (@(posedge CLK) disable iff (RST)
    (via_port && named.offset == SDM_OFF_PORT2 && PTR2_SECTOR < 8'h04)
      |-> (tgt.sector == PTR2_SECTOR[1:0] && tgt.offset == PTR2_LOW))
    else $error("third port not following its pointer");
  a_ptr_bad_sector: assert property (@(posedge CLK) disable iff (RST)
    (via_port && named.offset != SDM_OFF_PORT0 && !tgt.sector_ok)
      |-> (!tgt_gp && !tgt_sfr && !tgt_local))
    else $error("missing sector reached storage");
  a_gp_upper_half: assert property (@(posedge CLK) disable iff (RST)
    (tgt.sector_ok && tgt.offset >= SDM_GP_BASE)
      |-> (tgt_gp && !tgt_sfr))
    else $error("upper half not decoded to ram");

  // storage and strobes
  a_ptr_hold: assert property (@(posedge CLK) disable iff (RST)
    !(is_wr && tgt_local)
      |=> ($stable(PTR0) && $stable(PTR1_LOW) && $stable(PTR1_SECTOR) &&
           $stable(PTR2_LOW) && $stable(PTR2_SECTOR)))
    else $error("pointer changed without a write");
  a_ptr_bit_set: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_BSET && tgt_local && tgt.offset == SDM_OFF_PTR0)
      |=> (PTR0 == ($past(PTR0) | (8'h01 << $past(REQ.bitsel)))))
    else $error("bit set on pointer zero wrong");
  a_bit_set_only: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_BSET && tgt_gp)
      |-> (new_val[REQ.bitsel] &&
           (new_val | (8'h01 << REQ.bitsel)) == (ram_rdata | (8'h01 << REQ.bitsel))))
    else $error("bit set touched other bits");
  a_bit_clear_only: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_BCLR && tgt_gp)
      |-> (!new_val[REQ.bitsel] &&
           (new_val | (8'h01 << REQ.bitsel)) == (ram_rdata | (8'h01 << REQ.bitsel))))
    else $error("bit clear touched other bits");
  a_read_pulse: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_READ)
      |=> RVALID)
    else $error("read gave no valid pulse");
  a_rdata_hold: assert property (@(posedge CLK) disable iff (RST)
    !(REQ.valid && REQ.op == SDM_OP_READ)
      |=> (!RVALID && $stable(RDATA)))
    else $error("read data moved without a read");
  a_sfr_rd_hit: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_READ && !(tgt_sfr && SFR_HIT))
      |=> !SFR_RD)
    else $error("read strobe to absent register");
  a_sfr_read_value: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && REQ.op == SDM_OP_READ && tgt_sfr && SFR_HIT)
      |=> (SFR_RD && RDATA == $past(SFR_RDATA)))
    else $error("special register read lost");
  a_sfr_wr_strobe: assert property (@(posedge CLK) disable iff (RST)
    (is_wr && tgt_sfr && SFR_HIT && !SFR_RO)
      |=> (SFR_WR && SFR_ADDR == $past(tgt.offset) && SFR_WDATA == $past(new_val)))
    else $error("special register write lost");
  a_gp_no_strobe: assert property (@(posedge CLK) disable iff (RST)
    (REQ.valid && tgt_gp)
      |=> (!SFR_WR && !SFR_RD))
    else $error("ram access strobed special side");
  a_ram_write_read: assert property (@(posedge CLK) disable iff (RST)
    (last_wr_reg && REQ.valid && REQ.op == SDM_OP_READ && tgt_gp && ram_addr == last_addr_reg)
      |=> (RDATA == $past(last_val_reg)))
    else $error("ram read missed the last write");

  c_ext_ram_write: cover property (@(posedge CLK) disable iff (RST)
    REQ.valid && REQ.mode == SDM_MODE_EXT && tgt_gp && tgt.sector == 2'd3 && is_wr);
  c_port2_read: cover property (@(posedge CLK) disable iff (RST)
    REQ.valid && via_port && named.offset == SDM_OFF_PORT2 && tgt_gp);
  c_bit_set: cover property (@(posedge CLK) disable iff (RST)
    REQ.valid && REQ.op == SDM_OP_BSET && tgt_gp);
  c_port_self_write: cover property (@(posedge CLK) disable iff (RST)
    is_wr && tgt_port);
  c_ro_write: cover property (@(posedge CLK) disable iff (RST)
    is_wr && tgt_sfr && SFR_HIT && SFR_RO);
endmodule
`default_nettype wire

// ===== src/sdm_pkg.sv
`default_nettype none
package sdm_pkg;
  localparam int SDM_SECTORS = 4;
  localparam int SDM_SEC_W = 2;
  localparam int SDM_ADDR_W = 10;
  localparam logic [7:0] SDM_GP_BASE = 8'h80;
  localparam logic [7:0] SDM_SFR_LAST = 8'h7f;
  localparam logic [7:0] SDM_OFF_PORT0 = 8'h00;
  localparam logic [7:0] SDM_OFF_PTR0 = 8'h01;
  localparam logic [7:0] SDM_OFF_PORT1 = 8'h02;
  localparam logic [7:0] SDM_OFF_PTR1L = 8'h03;
  localparam logic [7:0] SDM_OFF_PTR1S = 8'h04;
  localparam logic [7:0] SDM_OFF_PORT2 = 8'h0c;
  localparam logic [7:0] SDM_OFF_PTR2L = 8'h0d;
  localparam logic [7:0] SDM_OFF_PTR2S = 8'h0e;
  localparam logic [7:0] SDM_PTR_RESET = 8'h00;
  localparam logic [7:0] SDM_ZERO = 8'h00;

  typedef enum logic [1:0] {SDM_MODE_DIRECT, SDM_MODE_EXT} sdm_mode_e;
  typedef enum logic [1:0] {SDM_OP_READ, SDM_OP_WRITE, SDM_OP_BSET, SDM_OP_BCLR} sdm_op_e;

  typedef struct packed {
    logic valid;
    sdm_mode_e mode;
    sdm_op_e op;
    logic [SDM_ADDR_W-1:0] addr;
    logic [2:0] bitsel;
    logic [7:0] wdata;
  } sdm_req_s;

  typedef struct packed {
    logic sector_ok;
    logic [SDM_SEC_W-1:0] sector;
    logic [7:0] offset;
  } sdm_loc_s;
endpackage
`default_nettype wire

// ===== src/sdm_gp_ram.sv
`default_nettype none
module sdm_gp_ram
  import sdm_pkg::*;
#(
  parameter int SECTORS = SDM_SECTORS
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(SECTORS)+6:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [$clog2(SECTORS)+6:0] raddr,
  output logic [7:0] rdata
);
  if (SECTORS < 1 || SECTORS > SDM_SECTORS) begin : g_bad_sectors
    $error("sdm_gp_ram: bad sector count");
  end

  // 128 bytes per sector, upper half of each sector
  logic [7:0] mem [SECTORS*128];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule
`default_nettype wire

// ===== tb/sdm_sfr_model.sv
`default_nettype none
module sdm_sfr_model
  import sdm_pkg::*;
(
  input wire logic CLK,
  input wire sdm_req_s REQ,
  input wire logic [7:0] PTR0,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  output logic SFR_RO
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] scratch_reg = 8'h00;
  logic [7:0] off;
  // only the first port is followed; tests reach special space by a sector-zero address, direct or extended, except one read of sector one
  always_comb begin
    off = REQ.addr[7:0];
    if (REQ.addr[9:8] == 2'h0 && off == SDM_OFF_PORT0) begin
      off = PTR0;
    end
  end
  assign SFR_HIT = off == 8'h0a || off == 8'h40;
  assign SFR_RO = off == 8'h40;
  // absent places drive ff so a design that passes it through is caught
  assign SFR_RDATA = off == 8'h40 ? 8'h5a : (off == 8'h0a ? scratch_reg : 8'hff);
  always_ff @(posedge CLK) begin
    if (SFR_WR && SFR_ADDR == 8'h0a) begin
      scratch_reg <= SFR_WDATA;
    end
  end
endmodule
`default_nettype wire

// ===== tb/sectored_data_memory_addressing_tb.sv
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, got, exp); end end
module sectored_data_memory_addressing_tb
  import sdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam sdm_mode_e EX = SDM_MODE_EXT;
  localparam sdm_mode_e DI = SDM_MODE_DIRECT;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  sdm_req_s req = '0;
  logic [7:0] rdata, sfr_addr, sfr_wdata, sfr_rdata, p0, p1l, p1s, p2l, p2s;
  logic rvalid, sfr_rd, sfr_wr, sfr_hit, sfr_ro;
  int err_total = 0;
  int checks_done = 0;
  always #10 CLK = ~CLK;
  sdm_data_mem dut_u (.CLK(CLK), .RST(RST), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
    .SFR_ADDR(sfr_addr), .SFR_RD(sfr_rd), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata),
    .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit), .SFR_RO(sfr_ro), .PTR0(p0),
    .PTR1_LOW(p1l), .PTR1_SECTOR(p1s), .PTR2_LOW(p2l), .PTR2_SECTOR(p2s));
  sdm_sfr_model sfr_u (.CLK(CLK), .REQ(req), .PTR0(p0), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit),
    .SFR_RO(sfr_ro));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one request per falling edge; valid stays up for back-to-back use
  task automatic put(sdm_mode_e m, sdm_op_e o, logic [9:0] a, logic [2:0] b, logic [7:0] d);
    @(negedge CLK);
    req = '{1'b1, m, o, a, b, d};
  endtask
  task automatic idle();
    @(negedge CLK);
    req.valid = 1'b0;
  endtask
  task automatic wr(sdm_mode_e m, logic [9:0] a, logic [7:0] d);
    put(m, SDM_OP_WRITE, a, 3'h0, d);
  endtask
  task automatic rd(sdm_mode_e m, logic [9:0] a, logic [7:0] e);
    put(m, SDM_OP_READ, a, 3'h0, 8'h00);
    idle();
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask
  task automatic t_sectors();
    for (int s = 0; s < 4; s++) begin
      wr(EX, {s[1:0], 8'h80}, 8'h10 + s[7:0]);
      wr(EX, {s[1:0], 8'hff}, 8'hf0 + s[7:0]);
    end
    for (int s = 0; s < 4; s++) begin
      rd(EX, {s[1:0], 8'h80}, 8'h10 + s[7:0]);
      rd(EX, {s[1:0], 8'hff}, 8'hf0 + s[7:0]);
    end
    wr(EX, 10'h381, 8'h66);
    wr(DI, 10'h381, 8'h77);
    rd(EX, 10'h081, 8'h77);
    rd(EX, 10'h381, 8'h66);
    rd(EX, 10'h17f, 8'h00);
    $display("sectors done");
  endtask
  task automatic t_bits();
    wr(EX, 10'h2a5, 8'ha5);
    put(EX, SDM_OP_BSET, 10'h2a5, 3'h1, 8'h00);
    put(EX, SDM_OP_BCLR, 10'h2a5, 3'h7, 8'h00);
    rd(EX, 10'h2a5, 8'h27);
    put(DI, SDM_OP_BSET, 10'h001, 3'h3, 8'h00);
    idle();
    `CHK(p0, 8'h08)
    $display("bits done");
  endtask
  task automatic t_ptrs();
    wr(DI, 10'h001, 8'h85);
    wr(DI, 10'h003, 8'ha0);
    wr(DI, 10'h004, 8'h02);
    wr(DI, 10'h00d, 8'hc0);
    wr(DI, 10'h00e, 8'h03);
    idle();
    `CHK({p0, p1s, p1l, p2s, p2l}, 40'h85_02a0_03c0)
    rd(DI, 10'h004, 8'h02);
    wr(DI, 10'h000, 8'h11);
    rd(EX, 10'h085, 8'h11);
    wr(DI, 10'h002, 8'h22);
    rd(EX, 10'h2a0, 8'h22);
    wr(DI, 10'h00c, 8'h33);
    rd(EX, 10'h3c0, 8'h33);
    rd(DI, 10'h00c, 8'h33);
    wr(DI, 10'h004, 8'h05);
    wr(DI, 10'h002, 8'h44);
    rd(DI, 10'h002, 8'h00);
    rd(EX, 10'h2a0, 8'h22);
    $display("pointers done");
  endtask
  task automatic t_special();
    wr(DI, 10'h001, 8'h00);
    rd(DI, 10'h000, 8'h00);
    wr(DI, 10'h000, 8'h55);
    rd(DI, 10'h000, 8'h00);
    `CHK(p0, 8'h00)
    rd(DI, 10'h00b, 8'h00);
    `CHK(sfr_rd, 1'b0)
    rd(DI, 10'h040, 8'h5a);
    `CHK({sfr_rd, sfr_addr}, 9'h1_40)
    wr(DI, 10'h040, 8'h00);
    idle();
    `CHK(sfr_wr, 1'b0)
    rd(DI, 10'h040, 8'h5a);
    wr(EX, 10'h00a, 8'h3c);
    idle();
    `CHK({sfr_wr, sfr_addr, sfr_wdata}, 17'h1_0a_3c)
    rd(DI, 10'h00a, 8'h3c);
    $display("special done");
  endtask
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge CLK);
    RST = 1'b0;
    `CHK({p0, p1l, p1s, p2l, p2s}, 40'h0)
    t_sectors();
    t_bits();
    t_ptrs();
    t_special();
    @(negedge CLK);
    RST = 1'b1;
    #1;
    `CHK({p0, p1s, p2s, rvalid}, 25'h0)
    @(negedge CLK);
    RST = 1'b0;
    rd(EX, 10'h3c0, 8'h33);
    $display("reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
